//--- common/pwm_pkg.sv
// shared constants and types for the three-phase center pwm block
package pwm_pkg;
	// ***************************************************************
	// widths
	// ***************************************************************
	localparam int TW = 12;  // timer and on-time width
	localparam int DW = 7;   // deadtime and deletion width
	localparam int AW = 4;   // register address width
	localparam int NPH = 3;  // number of phases

	// ***************************************************************
	// register map (word index on the address pins)
	// ***************************************************************
	localparam logic [AW-1:0] OFS_PERIOD = 4'h0;
	localparam logic [AW-1:0] OFS_ON1    = 4'h1;
	localparam logic [AW-1:0] OFS_ON2    = 4'h2;
	localparam logic [AW-1:0] OFS_ON3    = 4'h3;
	localparam logic [AW-1:0] OFS_DEAD   = 4'h4;
	localparam logic [AW-1:0] OFS_MINPW  = 4'h5;
	localparam logic [AW-1:0] OFS_STATUS = 4'h6;

	// ***************************************************************
	// reset values and status layout
	// ***************************************************************
	localparam logic [TW-1:0] RST_TIME = 12'h000;
	localparam logic [DW-1:0] RST_SMALL = 7'h00;
	localparam int STAT_LIVE = 0;
	localparam int STAT_STOP = 1;
	localparam int STAT_SEEN = 2;  // three bits, one per phase

	// ***************************************************************
	// timing
	// ***************************************************************
	localparam int CLK_PERIOD_NS = 8;                 // 125 MHz
	localparam logic [TW-1:0] LEAD_CLKS = 12'h004;    // calc window
	localparam logic [TW-1:0] ONE = 12'h001;

	// per-cycle recalculation stages, one clock each except CALC_RUN
	typedef enum logic [2:0] {
		CALC_RUN,
		CALC_LATCH,
		CALC_EDGES,
		CALC_GUARD,
		CALC_COMMIT
	} calc_t;
endpackage : pwm_pkg

//--- common/phase_if.sv
// timing bundle between the pwm core and one phase leg
`timescale 1ns/10ps
interface phase_if;
	import pwm_pkg::*;
	logic [TW-1:0] t;        // position in the cycle
	logic [TW-1:0] period;   // period for the next cycle
	logic [TW-1:0] on_time;  // complete on-time set for next cycle
	logic [DW-1:0] dead;     // even deadtime in clocks
	logic [DW-1:0] min_pw;   // deletion threshold
	calc_t         calc;     // recalculation stage
	logic          main_on;  // main switch wanted on
	logic          comp_on;  // complement switch wanted on
	logic          deleted;  // pulse deleted this cycle
	modport ctl (output t, period, on_time, dead, min_pw, calc,
		input main_on, comp_on, deleted);
	modport leg (input t, period, on_time, dead, min_pw, calc,
		output main_on, comp_on, deleted);
endinterface : phase_if

//--- hdl/pwm_leg.sv
// one inverter leg: edge computation, deadtime and pulse deletion
`timescale 1ns/10ps
module pwm_leg (
	input  wire logic clk,
	input  wire logic reset,
	phase_if.leg      ph
);
	import pwm_pkg::*;

	logic [TW-1:0] on_ff, per_ff, nxt_lo, nxt_hi, lo_ff, hi_ff;
	logic          nxt_del, del_ff;
	logic [TW:0]   t_w, dt_w;

	// ***************************************************************
	// edge computation in the last four clocks of a cycle
	// ***************************************************************
	// working edges change only at commit so the running cycle is clean
	always_ff @(posedge clk) begin
		if (reset) begin
			on_ff   <= RST_TIME;
			per_ff  <= RST_TIME;
			nxt_lo  <= RST_TIME;
			nxt_hi  <= RST_TIME;
			nxt_del <= 1'b0;
			lo_ff   <= RST_TIME;
			hi_ff   <= RST_TIME;
			del_ff  <= 1'b0;
		end else begin
			case (ph.calc)
				CALC_LATCH: begin
					on_ff  <= ph.on_time;
					per_ff <= ph.period;
				end
				CALC_EDGES: begin  // centre the pulse
					if (on_ff >= per_ff) begin
						on_ff  <= per_ff;
						nxt_lo <= RST_TIME;
					end else begin
						nxt_lo <= (per_ff - on_ff) >> 1;
					end
				end
				CALC_GUARD: begin
					nxt_hi  <= nxt_lo + on_ff;
					nxt_del <= on_ff < {{(TW-DW){1'b0}}, ph.min_pw};
				end
				CALC_COMMIT: begin
					lo_ff  <= nxt_lo;
					hi_ff  <= nxt_hi;
					del_ff <= nxt_del;
				end
				default: begin
				end
			endcase
		end
	end

	// ***************************************************************
	// compare against the cycle position
	// ***************************************************************
	assign t_w  = {1'b0, ph.t};
	assign dt_w = {{(TW+1-DW){1'b0}}, ph.dead};
	// complement waits one deadtime on each side of the main pulse
	assign ph.main_on = !del_ff && ph.t >= lo_ff && ph.t < hi_ff;
	assign ph.comp_on = del_ff || (t_w + dt_w < {1'b0, lo_ff})
		|| (t_w >= {1'b0, hi_ff} + dt_w);
	assign ph.deleted = del_ff;

	chk_delete_holds: assert property (@(posedge clk) disable iff (reset)
		del_ff |-> !ph.main_on && ph.comp_on)
		else $error("deleted leg not held off");
	chk_leg_overlap: assert property (@(posedge clk) disable iff (reset)
		!(ph.main_on && ph.comp_on))
		else $error("main and complement both on");
endmodule : pwm_leg

//--- hdl/three_phase_center_pwm.sv
// three-phase center-based pwm with deadtime, deletion and shutdown
`timescale 1ns/10ps

// Operation
// - twelve-bit timers counting whole clocks
// - three centred phases from own on-times
// - six outputs, complement pairs with deadtime
// - cycle length equals period register
// - edges placed on single clock granularity
// - all six outputs active low
// - duty equals on-time over period
// - one-clock start pulse each cycle
// - new on-times apply after all three
// - final four clocks compute next edges
// - delay between complementary edges per pair
// - even deadtime register, zero to 126
// - seven-bit deletion threshold, zero to 127
// - short pulse: main off, complement on
// - shutdown high forces outputs inactive high
// - shutdown low resumes normal outputs
module three_phase_center_pwm (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic [pwm_pkg::AW-1:0] addr,
	input  wire logic [pwm_pkg::TW-1:0] data_in,
	output logic      [pwm_pkg::TW-1:0] data_out,
	output logic                       data_oe,
	input  wire logic                  cs_n,
	input  wire logic                  wr_n,
	input  wire logic                  rd_n,
	input  wire logic                  stop,
	output logic                       cycle_start_pulse,
	output logic      [pwm_pkg::NPH-1:0] main_n,
	output logic      [pwm_pkg::NPH-1:0] comp_n
);
	import pwm_pkg::*;

	localparam int SW = 4 + AW + TW;  // synchronised pin bundle
	localparam logic [SW-1:0] SYNC_RST = {3'b111, 1'b0,
		{AW{1'b0}}, {TW{1'b0}}};

	// ***************************************************************
	// declarations
	// ***************************************************************
	logic [SW-1:0]  s1_ff, s2_ff, d_ff;
	logic           cs_n_s, wr_n_s, rd_n_s, stop_s;
	logic           cs_n_d, wr_n_d, rd_n_d, stop_d;
	logic [AW-1:0]  addr_s, addr_d;
	logic [TW-1:0]  din_s, din_d;
	logic           wr_evt;

	logic [TW-1:0]  period_ff;
	logic [TW-1:0]  shad_on_ff [NPH];
	logic [TW-1:0]  pend_on_ff [NPH];
	logic [DW-1:0]  dead_ff, minpw_ff;
	logic [NPH-1:0] seen_ff, wr_on, nxt_seen;
	logic           period_set_ff, ons_set_ff;

	logic [TW-1:0]  t_ff, per_ff, per_pend_ff;
	logic           armed_ff, live_ff;
	calc_t          calc;

	logic [TW-1:0]  nxt_rd;
	logic           sync_ff;
	logic [NPH-1:0] main_n_ff, comp_n_ff;
	logic           oe_ff;
	logic [TW-1:0]  dout_ff;

	phase_if ph [NPH] ();

	// ***************************************************************
	// pin synchronisers
	// ***************************************************************
	// every bus pin and the shutdown pin pass two flops first
	always_ff @(posedge clk) begin
		if (reset) begin
			s1_ff <= SYNC_RST;
			s2_ff <= SYNC_RST;
		end else begin
			s1_ff <= {cs_n, wr_n, rd_n, stop, addr, data_in};
			s2_ff <= s1_ff;
		end
	end

	// delayed copy, so a write is taken with the values held before
	// write strobe rose
	always_ff @(posedge clk) begin
		if (reset) begin
			d_ff <= SYNC_RST;
		end else begin
			d_ff <= s2_ff;
		end
	end

	assign {cs_n_s, wr_n_s, rd_n_s, stop_s, addr_s, din_s} = s2_ff;
	assign {cs_n_d, wr_n_d, rd_n_d, stop_d, addr_d, din_d} = d_ff;

	// write completes on the rising edge of the write strobe
	assign wr_evt = !cs_n_d && !wr_n_d && wr_n_s;

	// ***************************************************************
	// register writes
	// ***************************************************************
	// period, deadtime and deletion threshold
	always_ff @(posedge clk) begin
		if (reset) begin
			period_ff     <= RST_TIME;
			dead_ff       <= RST_SMALL;
			minpw_ff      <= RST_SMALL;
			period_set_ff <= 1'b0;
		end else if (wr_evt) begin
			case (addr_d)
				OFS_PERIOD: begin
					period_ff     <= din_d;
					period_set_ff <= 1'b1;
				end
				OFS_DEAD: begin  // lsb forced low
					dead_ff <= {din_d[DW-1:1], 1'b0};
				end
				OFS_MINPW: begin
					minpw_ff <= din_d[DW-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// on-time write strobes per phase
	assign wr_on[0] = wr_evt && addr_d == OFS_ON1;
	assign wr_on[1] = wr_evt && addr_d == OFS_ON2;
	assign wr_on[2] = wr_evt && addr_d == OFS_ON3;
	assign nxt_seen = seen_ff | wr_on;

	// shadow each on-time; a partial set never reaches the legs
	genvar gi;
	generate
		for (gi = 0; gi < NPH; gi++) begin : g_on
			always_ff @(posedge clk) begin
				if (reset) begin
					shad_on_ff[gi] <= RST_TIME;
					pend_on_ff[gi] <= RST_TIME;
				end else begin
					if (wr_on[gi]) begin
						shad_on_ff[gi] <= din_d;
					end
					if (&nxt_seen) begin
						pend_on_ff[gi] <= wr_on[gi] ? din_d
							: shad_on_ff[gi];
					end
				end
			end
		end
	endgenerate

	// track which on-times have been written since the last full set
	always_ff @(posedge clk) begin
		if (reset) begin
			seen_ff    <= '0;
			ons_set_ff <= 1'b0;
		end else if (&nxt_seen) begin
			seen_ff    <= '0;
			ons_set_ff <= 1'b1;
		end else begin
			seen_ff <= nxt_seen;
		end
	end

	// ***************************************************************
	// cycle timer
	// ***************************************************************
	// timer starts only once period and a full on-time set exist;
	// it begins four clocks before the first boundary so the first
	// cycle already has computed edges. periods below eight clocks
	// are not supported.
	always_ff @(posedge clk) begin
		if (reset) begin
			t_ff     <= RST_TIME;
			per_ff   <= RST_TIME;
			armed_ff <= 1'b0;
		end else if (!armed_ff) begin
			if (period_set_ff && ons_set_ff) begin
				armed_ff <= 1'b1;
				per_ff   <= period_ff;
				t_ff     <= period_ff - LEAD_CLKS;
			end
		end else if (calc == CALC_COMMIT) begin
			t_ff   <= RST_TIME;
			per_ff <= per_pend_ff;
		end else begin
			t_ff <= t_ff + ONE;  // one clock per step
		end
	end

	// period for the next cycle is sampled with the on-times
	always_ff @(posedge clk) begin
		if (reset) begin
			per_pend_ff <= RST_TIME;
		end else if (calc == CALC_LATCH) begin
			per_pend_ff <= period_ff;
		end
	end

	// recalculation stage from the cycle position
	always_comb begin
		calc = CALC_RUN;
		if (armed_ff) begin
			if (t_ff == per_ff - LEAD_CLKS) begin
				calc = CALC_LATCH;
			end else if (t_ff == per_ff - LEAD_CLKS + ONE) begin
				calc = CALC_EDGES;
			end else if (t_ff == per_ff - ONE - ONE) begin
				calc = CALC_GUARD;
			end else if (t_ff == per_ff - ONE) begin
				calc = CALC_COMMIT;
			end
		end
	end

	// outputs go live at the first boundary after arming
	always_ff @(posedge clk) begin
		if (reset) begin
			live_ff <= 1'b0;
		end else if (calc == CALC_COMMIT) begin
			live_ff <= 1'b1;
		end
	end

	// ***************************************************************
	// phase legs
	// ***************************************************************
	generate
		for (gi = 0; gi < NPH; gi++) begin : g_leg
			assign ph[gi].t       = t_ff;
			assign ph[gi].period  = period_ff;
			assign ph[gi].on_time = pend_on_ff[gi];
			assign ph[gi].dead    = dead_ff;
			assign ph[gi].min_pw  = minpw_ff;
			assign ph[gi].calc    = calc;

			pwm_leg u_leg (
				.clk   (clk),
				.reset (reset),
				.ph    (ph[gi])
			);

			// active low drive, gated by shutdown and the live flag
			always_ff @(posedge clk) begin
				if (reset) begin
					main_n_ff[gi] <= 1'b1;
					comp_n_ff[gi] <= 1'b1;
				end else begin
					main_n_ff[gi] <= !(live_ff && !stop_s
						&& ph[gi].main_on);
					comp_n_ff[gi] <= !(live_ff && !stop_s
						&& ph[gi].comp_on);
				end
			end
		end
	endgenerate

	// ***************************************************************
	// cycle start pulse
	// ***************************************************************
	// high for the clock in which the timer sits at zero
	always_ff @(posedge clk) begin
		if (reset) begin
			sync_ff <= 1'b0;
		end else begin
			sync_ff <= calc == CALC_COMMIT;
		end
	end

	// ***************************************************************
	// register reads
	// ***************************************************************
	// unmapped addresses read as zero
	always_comb begin
		nxt_rd = RST_TIME;
		case (addr_s)
			OFS_PERIOD: nxt_rd = period_ff;
			OFS_ON1:    nxt_rd = shad_on_ff[0];
			OFS_ON2:    nxt_rd = shad_on_ff[1];
			OFS_ON3:    nxt_rd = shad_on_ff[2];
			OFS_DEAD:   nxt_rd = {{(TW-DW){1'b0}}, dead_ff};
			OFS_MINPW:  nxt_rd = {{(TW-DW){1'b0}}, minpw_ff};
			OFS_STATUS: begin
				nxt_rd[STAT_LIVE] = live_ff;
				nxt_rd[STAT_STOP] = stop_s;
				nxt_rd[STAT_SEEN +: NPH] = seen_ff;
			end
			default: nxt_rd = RST_TIME;
		endcase
	end

	// data bus driven while chip select and read strobe are low
	always_ff @(posedge clk) begin
		if (reset) begin
			oe_ff   <= 1'b0;
			dout_ff <= RST_TIME;
		end else begin
			oe_ff   <= !cs_n_s && !rd_n_s;
			dout_ff <= nxt_rd;
		end
	end

	assign data_out          = dout_ff;
	assign data_oe           = oe_ff;
	assign cycle_start_pulse = sync_ff;
	assign main_n            = main_n_ff;
	assign comp_n            = comp_n_ff;

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	chk_sync_width: assert property (
		sync_ff |=> !sync_ff)
		else $error("cycle start pulse longer than one clock");
	chk_sync_at_zero: assert property (
		sync_ff |-> t_ff == RST_TIME && live_ff)
		else $error("cycle start pulse away from cycle start");
	chk_stop_high: assert property (
		stop_s |=> main_n_ff == '1 && comp_n_ff == '1)
		else $error("outputs active during shutdown");
	chk_stop_resume: assert property (
		!stop_s && live_ff && ph[0].main_on |=> !main_n_ff[0])
		else $error("phase one not resumed after shutdown");
	chk_idle_high: assert property (
		!live_ff |=> main_n_ff == '1 && comp_n_ff == '1)
		else $error("outputs active before setup");
	chk_pair_apart: assert property (
		(main_n_ff | comp_n_ff) == '1)
		else $error("both switches of a leg on");
	chk_dead_even: assert property (
		!dead_ff[0])
		else $error("deadtime register odd");
	chk_partial_hold: assert property (
		wr_evt && !(&nxt_seen) |=> $stable(pend_on_ff[0])
			&& $stable(pend_on_ff[1]) && $stable(pend_on_ff[2]))
		else $error("partial on-time set reached the legs");
	chk_timer_range: assert property (
		live_ff |-> t_ff < per_ff)
		else $error("cycle timer beyond period");
	chk_calc_span: assert property (
		calc == CALC_LATCH |=> calc == CALC_EDGES ##1
			calc == CALC_GUARD ##1 calc == CALC_COMMIT)
		else $error("recalculation window not four clocks");

	cov_cycle: cover property (sync_ff ##[1:300] sync_ff);
	cov_stop: cover property (live_ff && $rose(stop_s));
	cov_delete: cover property (live_ff && ph[1].deleted);
	cov_update: cover property (wr_evt && &nxt_seen);
endmodule : three_phase_center_pwm

//--- sim/gate_drive_model.sv
// gate drive stage model: measures the six active-low gate lines
`timescale 1ns/10ps
module gate_drive_model (
	input  wire logic                                   clk,
	input  wire logic                                   clr,
	input  wire logic                                   cycle_start_pulse,
	input  wire logic [pwm_pkg::NPH-1:0]                main_n,
	input  wire logic [pwm_pkg::NPH-1:0]                comp_n,
	output logic      [pwm_pkg::NPH-1:0][pwm_pkg::TW-1:0] main_cnt,
	output logic      [pwm_pkg::NPH-1:0][pwm_pkg::TW-1:0] comp_cnt,
	output logic      [pwm_pkg::NPH-1:0][pwm_pkg::TW-1:0] first_on,
	output logic      [pwm_pkg::TW-1:0]                 cyc_len,
	output logic                                        shoot
);
	import pwm_pkg::*;
	// ***************************************************************
	// per-cycle measurement
	// ***************************************************************
	logic [NPH-1:0][TW-1:0] run_m;
	logic [NPH-1:0][TW-1:0] run_c;
	logic [NPH-1:0][TW-1:0] run_f;
	logic [TW-1:0]          idx;

	initial begin
		idx = '0;
		run_m = '0;
		run_c = '0;
		run_f = '1;
		shoot = 1'b0;
	end

	// counts are published at each start pulse, so a lag of the gate
	// lines behind the pulse shifts the window but not the totals
	always @(posedge clk) begin
		if (cycle_start_pulse) begin
			main_cnt = run_m;
			comp_cnt = run_c;
			first_on = run_f;
			cyc_len = idx;
			idx = '0;
			run_m = '0;
			run_c = '0;
			run_f = '1;
		end
		for (int i = 0; i < NPH; i++) begin
			if (!main_n[i]) begin // low turns the switch on
				run_m[i] = run_m[i] + ONE;
				if (run_f[i] == '1)
					run_f[i] = idx;
			end
			if (!comp_n[i])
				run_c[i] = run_c[i] + ONE;
			if (!main_n[i] && !comp_n[i]) // both switches of a leg on
				shoot = 1'b1;
		end
		idx = idx + ONE;
		if (clr)
			shoot = 1'b0;
	end
endmodule : gate_drive_model

//--- sim/testbench.sv
// self-checking testbench for the three-phase center pwm block
`timescale 1ns/10ps
module testbench;
	import pwm_pkg::*;
	// ***************************************************************
	// signals and instances
	// ***************************************************************
	logic                   clk;
	logic                   reset;
	logic [AW-1:0]          addr;
	logic [TW-1:0]          host_data;
	logic [TW-1:0]          data_in;
	logic [TW-1:0]          data_out;
	logic                   data_oe;
	logic                   cs_n;
	logic                   wr_n;
	logic                   rd_n;
	logic                   stop;
	logic                   clr;
	logic                   cycle_start_pulse;
	logic [NPH-1:0]         main_n;
	logic [NPH-1:0]         comp_n;
	logic [NPH-1:0][TW-1:0] main_cnt;
	logic [NPH-1:0][TW-1:0] comp_cnt;
	logic [NPH-1:0][TW-1:0] first_on;
	logic [TW-1:0]          cyc_len;
	logic                   shoot;
	int                     err_count;
	int                     total_checks;

	// shared data pins: the device wins while it drives
	assign data_in = data_oe ? data_out : host_data;

	three_phase_center_pwm u_three_phase_center_pwm (
		.clk(clk), .reset(reset), .addr(addr), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .cs_n(cs_n),
		.wr_n(wr_n), .rd_n(rd_n), .stop(stop),
		.cycle_start_pulse(cycle_start_pulse),
		.main_n(main_n), .comp_n(comp_n)
	);

	gate_drive_model u_gate_drive_model (
		.clk(clk), .clr(clr), .cycle_start_pulse(cycle_start_pulse),
		.main_n(main_n), .comp_n(comp_n), .main_cnt(main_cnt),
		.comp_cnt(comp_cnt), .first_on(first_on), .cyc_len(cyc_len),
		.shoot(shoot)
	);

	always #(CLK_PERIOD_NS / 2) clk = ~clk;

	// ***************************************************************
	// tasks
	// ***************************************************************
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	task automatic chk(input string what, input logic [TW-1:0] seen,
		input logic [TW-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// write strobe held low three clocks, chip select four more after it rises, so the pin sync sees them
	task automatic wr(input logic [AW-1:0] a, input logic [TW-1:0] d);
		cs_n = 1'b0;
		addr = a;
		host_data = d;
		wr_n = 1'b0;
		repeat (3) @(negedge clk);
		wr_n = 1'b1;
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		host_data = ~d;
		repeat (4) @(negedge clk);
	endtask : wr

	task automatic rdchk(input logic [AW-1:0] a, input logic [TW-1:0] exp);
		int n;
		cs_n = 1'b0;
		addr = a;
		rd_n = 1'b0;
		host_data = ~host_data;
		n = 0;
		while (data_oe !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk("read enable", {11'h000, data_oe}, 12'h001);
		chk("read data", data_out, exp);
		rd_n = 1'b1;
		cs_n = 1'b1;
		repeat (5) @(negedge clk);
	endtask : rdchk

	task automatic next_pulse();
		int n;
		n = 0;
		while (cycle_start_pulse !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 5000) begin
			err_count++;
			finish_test();
		end
		@(negedge clk);
		chk("pulse width", {11'h000, cycle_start_pulse}, 12'h000);
	endtask : next_pulse

	// a set written late lands a cycle later, so three boundaries pass
	task automatic settle(input logic [TW-1:0] p, input logic [TW-1:0] o0,
		input logic [TW-1:0] o1, input logic [TW-1:0] o2,
		input logic [TW-1:0] dt, input logic [TW-1:0] thr);
		logic [TW-1:0] on [NPH];
		on = '{o0, o1, o2};
		repeat (3) next_pulse();
		chk("cycle length", cyc_len, p);
		for (int i = 0; i < NPH; i++) begin
			chk("main count", main_cnt[i], on[i] < thr ? '0 : on[i]);
			chk("comp count", comp_cnt[i],
				on[i] < thr ? p : p - on[i] - (dt << 1));
		end
	endtask : settle

	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		addr = '0;
		host_data = '0;
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		stop = 1'b0;
		clr = 1'b1;
		err_count = 0;
		total_checks = 0;
		repeat (5) @(negedge clk);
		reset = 1'b0;
		clr = 1'b0;
		chk("main idle", {9'h000, main_n}, 12'h007);
		chk("comp idle", {9'h000, comp_n}, 12'h007);
		chk("bus idle", {11'h000, data_oe}, 12'h000);
		for (int i = 0; i < 6; i++)
			rdchk(AW'(i), 12'h000);
		rdchk(4'hf, 12'h000);
		wr(OFS_PERIOD, 12'hfff);
		rdchk(OFS_PERIOD, 12'hfff);
		wr(OFS_DEAD, 12'h07f);
		rdchk(OFS_DEAD, 12'h07e);
		wr(OFS_MINPW, 12'h07f);
		rdchk(OFS_MINPW, 12'h07f);
		wr(4'h9, 12'h5a5);
		rdchk(4'h9, 12'h000);
		wr(OFS_ON1, 12'hfff);
		rdchk(OFS_ON1, 12'hfff);
		wr(OFS_ON2, 12'h004);
		repeat (40) @(negedge clk);
		chk("main unset", {9'h000, main_n & comp_n}, 12'h007);
		// nominal run: repeated write of one on-time must not finish the set
		wr(OFS_PERIOD, 12'h014);
		wr(OFS_DEAD, 12'h000);
		wr(OFS_MINPW, 12'h000);
		wr(OFS_ON1, 12'h008);
		rdchk(OFS_STATUS, 12'h00c);
		wr(OFS_ON3, 12'h00c);
		settle(12'h014, 12'h008, 12'h004, 12'h00c, 12'h000, 12'h000);
		chk("centre ab", first_on[0] - first_on[1], 12'hffe);
		chk("centre ac", first_on[0] - first_on[2], 12'h002);
		chk("pairs", {9'h000, main_n ^ comp_n}, 12'h007);
		// shutdown and resume, three clocks through the two-flop pin sync and output flop
		stop = 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("stop off", {6'h00, main_n, comp_n}, 12'h03f);
		repeat (30) @(negedge clk);
		chk("stop held", {6'h00, main_n, comp_n}, 12'h03f);
		rdchk(OFS_STATUS, 12'h003);
		stop = 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("resume", {9'h000, main_n ^ comp_n}, 12'h007);
		settle(12'h014, 12'h008, 12'h004, 12'h00c, 12'h000, 12'h000);
		// odd deadtime loses its low bit
		wr(OFS_DEAD, 12'h003);
		rdchk(OFS_DEAD, 12'h002);
		settle(12'h014, 12'h008, 12'h004, 12'h00c, 12'h002, 12'h000);
		// partial on-time update keeps the old timing
		wr(OFS_ON1, 12'h00a);
		wr(OFS_ON2, 12'h003);
		settle(12'h014, 12'h008, 12'h004, 12'h00c, 12'h002, 12'h000);
		rdchk(OFS_STATUS, 12'h00d);
		// deletion: on3 below threshold, on2 exactly at it survives
		wr(OFS_MINPW, 12'h003);
		wr(OFS_ON3, 12'h002);
		settle(12'h014, 12'h00a, 12'h003, 12'h002, 12'h002, 12'h003);
		chk("shoot through", {11'h000, shoot}, 12'h000);
		rdchk(OFS_STATUS, 12'h001);
		finish_test();
	end

	// watchdog: the whole sequence needs under a thousand clocks
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		finish_test();
	end
endmodule : testbench
